// >>> rtl/dsc_regs_top.sv
// Status and control registers of the transmit and receive loops.
// Assumes an AXI4-Lite master and loop status inputs synchronous to aclk.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// What this block does
// RL1 - Status bit 0 shows transmit loop holdover.
// RL2 - Status bit 1 shows transmit loop locked.
// RL3 - Status bit 2 shows selected reference failed.
// RL4 - Span field picks 12/52/130/83 ppm, default 83.
// RL5 - Build-out select 0 absorbs phase on switch.
// RL6 - Build-out select 1 realigns output phase.
// RL7 - Slope bit 0 caps 61 ms/s, 1 unlimited.
// RL8 - Revert bit picks revertive or non-revertive switching.
// RL9 - Offset bit enables free-run frequency offset.
// RL10 - Enable bit turns receive loop on, reset off.
// RL11 - Software keeps reserved defaults; status writes ignored.
module dsc_regs_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire dsc_pkg::dsc_tx_state_t tx_state,
  input  wire logic                  src_change,
  output dsc_pkg::dsc_rx_ctrl_t      rx_ctrl,
  output logic [1:0]                 span_code,
  output logic [7:0]                 span_ppm,
  output logic [7:0]                 slope_cap_ms,
  output logic                       phase_absorb,
  output logic                       phase_realign
);

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic        awready_q;
  logic        awready_d;
  logic        wready_q;
  logic        wready_d;
  logic        aw_have_q;
  logic        aw_have_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [7:0]  awaddr_q;
  logic [7:0]  wbyte_q;
  logic        wstrb0_q;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        wr_hit;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_byte;
  logic        wr_strb0;

  // Address and data are accepted in either order; the write happens
  // in the cycle where the second of the two is present.
  assign aw_take  = s_axi_awvalid & awready_q;
  assign w_take   = s_axi_wvalid & wready_q;
  assign wr_addr  = aw_take ? s_axi_awaddr : awaddr_q;
  assign wr_byte  = w_take ? s_axi_wdata[7:0] : wbyte_q;
  assign wr_strb0 = w_take ? s_axi_wstrb[0] : wstrb0_q;
  assign wr_fire  = (aw_have_q | aw_take) & (w_have_q | w_take) & ~bvalid_q;
  assign wr_hit   = (wr_addr == dsc_pkg::ADDR_TX_STATE)
                  | (wr_addr == dsc_pkg::ADDR_SPAN)
                  | (wr_addr == dsc_pkg::ADDR_RX_CTRL_A)
                  | (wr_addr == dsc_pkg::ADDR_RX_CTRL_B);

  always_comb begin
    aw_have_d = aw_have_q | aw_take;
    w_have_d  = w_have_q | w_take;
    bvalid_d  = bvalid_q & ~s_axi_bready;
    bresp_d   = bresp_q;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    end
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wbyte_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= wr_addr;
      wbyte_q   <= wr_byte;
      wstrb0_q  <= wr_strb0;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] span_q;
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic       span_we;
  logic       ctrl_a_we;
  logic       ctrl_b_we;

  // The status register has no write enable, so a write to it is
  // answered OKAY and changes nothing.
  assign span_we   = wr_fire & wr_strb0 & (wr_addr == dsc_pkg::ADDR_SPAN);
  assign ctrl_a_we = wr_fire & wr_strb0
                   & (wr_addr == dsc_pkg::ADDR_RX_CTRL_A);
  assign ctrl_b_we = wr_fire & wr_strb0
                   & (wr_addr == dsc_pkg::ADDR_RX_CTRL_B);

  always_comb begin
    status_d = 8'h00;
    status_d[dsc_pkg::HOLD_BIT] = tx_state.holdover; // RL1
    status_d[dsc_pkg::LOCK_BIT] = tx_state.locked;   // RL2
    status_d[dsc_pkg::FAIL_BIT] = tx_state.ref_fail; // RL3
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_d;
    end
  end

  dsc_byte_reg #(
    .RST_VAL (dsc_pkg::SPAN_RST),
    .WMASK   (dsc_pkg::SPAN_WMASK)
  ) u_span (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (span_we),
    .wr_data (wr_byte),
    .q       (span_q)
  );

  dsc_byte_reg #(
    .RST_VAL (dsc_pkg::CTRL_A_RST),
    .WMASK   (dsc_pkg::CTRL_A_WMASK)
  ) u_ctrl_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (ctrl_a_we),
    .wr_data (wr_byte),
    .q       (ctrl_a_q)
  );

  dsc_byte_reg #(
    .RST_VAL (dsc_pkg::CTRL_B_RST),
    .WMASK   (dsc_pkg::CTRL_B_WMASK)
  ) u_ctrl_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (ctrl_b_we),
    .wr_data (wr_byte),
    .q       (ctrl_b_q)
  );

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic        arready_q;
  logic        arready_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic        ar_take;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  assign ar_take = s_axi_arvalid & arready_q;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      dsc_pkg::ADDR_TX_STATE:  rd_byte = status_q;
      dsc_pkg::ADDR_SPAN:      rd_byte = span_q;
      dsc_pkg::ADDR_RX_CTRL_A: rd_byte = ctrl_a_q;
      dsc_pkg::ADDR_RX_CTRL_B: rd_byte = ctrl_b_q;
      default:                 rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, rd_byte};
      rresp_d  = rd_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= 2'h0;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ---------------------------------------------------------------
  // Loop control outputs
  // ---------------------------------------------------------------
  dsc_pkg::dsc_rx_ctrl_t ctrl_q;
  dsc_pkg::dsc_rx_ctrl_t ctrl_d;
  logic [1:0]            span_code_q;
  logic [7:0]            span_ppm_q;
  logic [7:0]            span_ppm_d;
  logic [7:0]            slope_q;
  logic [7:0]            slope_d;

  always_comb begin
    ctrl_d.phase_buildout_select = ctrl_a_q[dsc_pkg::BUILDOUT_BIT];
    ctrl_d.phase_rate_cap        = ctrl_a_q[dsc_pkg::RATE_BIT];
    ctrl_d.loop_en               = ctrl_a_q[dsc_pkg::LOOP_EN_BIT]; // RL10
    ctrl_d.revertive             = ctrl_b_q[dsc_pkg::REVERT_BIT];  // RL8
    ctrl_d.freq_offset_en        = ctrl_b_q[dsc_pkg::FOFS_BIT];    // RL9
    case (span_q[dsc_pkg::SPAN_LSB +: 2])
      dsc_pkg::SPAN_12:  span_ppm_d = dsc_pkg::PPM_12;  // RL4
      dsc_pkg::SPAN_52:  span_ppm_d = dsc_pkg::PPM_52;  // RL4
      dsc_pkg::SPAN_130: span_ppm_d = dsc_pkg::PPM_130; // RL4
      default:           span_ppm_d = dsc_pkg::PPM_83;  // RL4
    endcase
    // A zero cap tells the loop that the output slope is unlimited.
    slope_d = ctrl_a_q[dsc_pkg::RATE_BIT] ? dsc_pkg::SLOPE_NONE
                                          : dsc_pkg::SLOPE_CAP_MS; // RL7
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= '0;
      span_code_q <= 2'h3;
      span_ppm_q  <= dsc_pkg::PPM_83;
      slope_q     <= dsc_pkg::SLOPE_CAP_MS;
    end else begin
      ctrl_q      <= ctrl_d;
      span_code_q <= span_q[dsc_pkg::SPAN_LSB +: 2];
      span_ppm_q  <= span_ppm_d;
      slope_q     <= slope_d;
    end
  end

  assign rx_ctrl      = ctrl_q;
  assign span_code    = span_code_q;
  assign span_ppm     = span_ppm_q;
  assign slope_cap_ms = slope_q;

  dsc_src_switch u_src_switch (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .src_change   (src_change),
    .loop_en      (ctrl_a_q[dsc_pkg::LOOP_EN_BIT]),
    .buildout_sel (ctrl_a_q[dsc_pkg::BUILDOUT_BIT]),
    .absorb       (phase_absorb),
    .realign      (phase_realign)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_hold_flag_read: assert property ( // RL1
    ar_take && s_axi_araddr == dsc_pkg::ADDR_TX_STATE
    |=> s_axi_rdata[0] == $past(status_q[0]) && s_axi_rvalid)
    else $error("Holdover bit read back wrong.");

  chk_lock_flag: assert property ( // RL2
    $rose(tx_state.locked) |=> status_q[dsc_pkg::LOCK_BIT])
    else $error("Lock bit did not follow the loop.");

  // Qualified by reset so that the edge which releases reset, where the
  // status flop still loads its reset value, is not taken as a miss.
  chk_fail_flag: assert property ( // RL3
    aresetn && tx_state.ref_fail |=> status_q[dsc_pkg::FAIL_BIT])
    else $error("Reference fail bit missing.");

  chk_span_wide: assert property ( // RL4
    span_q[1:0] == 2'h2 ##1 span_q[1:0] == 2'h2 |-> span_ppm == 8'h82)
    else $error("Span code 2 not 130 ppm.");

  chk_span_narrow: assert property ( // RL4
    span_q[1:0] == 2'h0 |=> span_ppm == 8'h0C && span_code == 2'h0)
    else $error("Span code 0 not 12 ppm.");

  chk_absorb_pulse: assert property ( // RL5
    src_change && ctrl_a_q[7] && !ctrl_a_q[0]
    |=> phase_absorb && !phase_realign ##1 !phase_absorb || $past(src_change))
    else $error("Phase not absorbed on switch.");

  chk_realign_pulse: assert property ( // RL6
    src_change && ctrl_a_q[7] && ctrl_a_q[0]
    |=> phase_realign && !phase_absorb)
    else $error("Phase not realigned on switch.");

  chk_slope_cap: assert property ( // RL7
    !ctrl_a_q[4] |=> slope_cap_ms == 8'h3D)
    else $error("Slope cap not 61 ms/s.");

  chk_revert_write: assert property ( // RL8
    ctrl_b_we |-> ##2 rx_ctrl.revertive == $past(wr_byte[0], 2))
    else $error("Revert bit not applied.");

  chk_offset_write: assert property ( // RL9
    ctrl_b_we |-> ##2 rx_ctrl.freq_offset_en == $past(wr_byte[1], 2))
    else $error("Offset enable not applied.");

  chk_loop_gate: assert property ( // RL10
    !ctrl_a_q[7] |=> !phase_absorb && !phase_realign)
    else $error("Disabled loop reacted to switch.");

  cov_write_done: cover property (wr_fire && wr_hit);
  cov_status_read: cover property (
    ar_take && s_axi_araddr == dsc_pkg::ADDR_TX_STATE);
  cov_absorb: cover property (phase_absorb);
  cov_realign: cover property (phase_realign);

endmodule : dsc_regs_top

// >>> common/dsc_pkg.sv
// Constants and carrier types for the loop status and control registers.
// Assumes one 50 MHz clock and a 32-bit AXI4-Lite register port.
package dsc_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_TX_STATE   = 8'h28;
  localparam logic [7:0] IDX_SPAN       = 8'h29;
  localparam logic [7:0] IDX_RX_CTRL_A  = 8'h2A;
  localparam logic [7:0] IDX_RX_CTRL_B  = 8'h2B;
  localparam logic [7:0] ADDR_TX_STATE  = 8'(IDX_TX_STATE * 8'h04);
  localparam logic [7:0] ADDR_SPAN      = 8'(IDX_SPAN * 8'h04);
  localparam logic [7:0] ADDR_RX_CTRL_A = 8'(IDX_RX_CTRL_A * 8'h04);
  localparam logic [7:0] ADDR_RX_CTRL_B = 8'(IDX_RX_CTRL_B * 8'h04);

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HOLD_BIT    = 0;
  localparam int LOCK_BIT    = 1;
  localparam int FAIL_BIT    = 2;
  localparam int SPAN_LSB    = 0;
  localparam int BUILDOUT_BIT = 0;
  localparam int RATE_BIT    = 4;
  localparam int LOOP_EN_BIT = 7;
  localparam int REVERT_BIT  = 0;
  localparam int FOFS_BIT    = 1;

  // ---------------------------------------------------------------
  // Reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [7:0] SPAN_RST    = 8'h03;
  localparam logic [7:0] CTRL_A_RST  = 8'h00;
  localparam logic [7:0] CTRL_B_RST  = 8'h04;
  localparam logic [7:0] SPAN_WMASK  = 8'h03;
  localparam logic [7:0] CTRL_A_WMASK = 8'h91;
  localparam logic [7:0] CTRL_B_WMASK = 8'h03;

  // ---------------------------------------------------------------
  // Capture span in ppm and phase slope cap in ms/s
  // ---------------------------------------------------------------
  localparam logic [1:0] SPAN_12  = 2'h0;
  localparam logic [1:0] SPAN_52  = 2'h1;
  localparam logic [1:0] SPAN_130 = 2'h2;
  localparam logic [7:0] PPM_12   = 8'h0C;
  localparam logic [7:0] PPM_52   = 8'h34;
  localparam logic [7:0] PPM_130  = 8'h82;
  localparam logic [7:0] PPM_83   = 8'h53;
  localparam logic [7:0] SLOPE_CAP_MS = 8'h3D;
  localparam logic [7:0] SLOPE_NONE   = 8'h00;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ref_fail;
    logic locked;
    logic holdover;
  } dsc_tx_state_t;

  typedef struct packed {
    logic loop_en;
    logic freq_offset_en;
    logic revertive;
    logic phase_rate_cap;
    logic phase_buildout_select;
  } dsc_rx_ctrl_t;

endpackage : dsc_pkg

// >>> rtl/dsc_byte_reg.sv
// One byte-wide software register with fixed reserved bits.
// Assumes the caller has already qualified the write with address and strobe.
`timescale 1ns/1ns
module dsc_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK   = 8'hFF
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);

  logic [7:0] q_q;
  logic [7:0] q_d;

  // Reserved bits never take written data, so they keep their default.
  always_comb begin
    q_d = q_q;
    if (wr_en) begin
      q_d = (wr_data & WMASK) | (RST_VAL & ~WMASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule : dsc_byte_reg

// >>> rtl/dsc_src_switch.sv
// Source change handling of the receive loop: absorb or realign phase.
// Assumes src_change is a one-cycle pulse synchronous to aclk.
`timescale 1ns/1ns
module dsc_src_switch (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic src_change,
  input  wire logic loop_en,
  input  wire logic buildout_sel,
  output logic      absorb,
  output logic      realign
);

  logic absorb_q;
  logic absorb_d;
  logic realign_q;
  logic realign_d;

  // A disabled loop ignores source changes entirely.
  always_comb begin
    absorb_d  = src_change & loop_en & ~buildout_sel; // RL5
    realign_d = src_change & loop_en & buildout_sel;  // RL6
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      absorb_q  <= 1'b0;
      realign_q <= 1'b0;
    end else begin
      absorb_q  <= absorb_d;
      realign_q <= realign_d;
    end
  end

  assign absorb  = absorb_q;
  assign realign = realign_q;

endmodule : dsc_src_switch

// >>> dv/tb_top.sv
// Self-checking bench for the loop status and control registers.
// Assumes the design carries its own assertions and a single 50 MHz clock.
`timescale 1ns/1ns
module tb_top;

  // ---------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } dsc_note_t;

  logic                   aclk;
  logic                   aresetn;
  logic [7:0]             s_axi_awaddr;
  logic                   s_axi_awvalid;
  logic                   s_axi_awready;
  logic [31:0]            s_axi_wdata;
  logic [3:0]             s_axi_wstrb;
  logic                   s_axi_wvalid;
  logic                   s_axi_wready;
  logic [1:0]             s_axi_bresp;
  logic                   s_axi_bvalid;
  logic                   s_axi_bready;
  logic [7:0]             s_axi_araddr;
  logic                   s_axi_arvalid;
  logic                   s_axi_arready;
  logic [31:0]            s_axi_rdata;
  logic [1:0]             s_axi_rresp;
  logic                   s_axi_rvalid;
  logic                   s_axi_rready;
  dsc_pkg::dsc_tx_state_t tx_state;
  logic                   src_change;
  dsc_pkg::dsc_rx_ctrl_t  rx_ctrl;
  logic [1:0]             span_code;
  logic [7:0]             span_ppm;
  logic [7:0]             slope_cap_ms;
  logic                   phase_absorb;
  logic                   phase_realign;
  dsc_note_t              bq[$];
  dsc_note_t              rq[$];
  dsc_note_t              nt;
  int                     fails;
  int                     checks;

  dsc_regs_top dsc_regs_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_state, .src_change, .rx_ctrl, .span_code, .span_ppm, .slope_cap_ms,
    .phase_absorb, .phase_realign
  );

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // Compare, finish and bus tasks
  // ---------------------------------------------------------------
  task automatic cmp_bus(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_bus

  task automatic cmp_port(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_port

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Entering on a fresh edge keeps two tasks from driving one time step.
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] s, input logic [1:0] r);
    logic aw_go;
    logic w_go;
    logic aw_done;
    logic w_done;
    logic got;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge aclk);
    bq.push_back('{data: 32'h0, resp: r});
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_go) begin
        s_axi_awvalid <= 1'h0;
        aw_done = 1'h1;
      end
      if (w_go) begin
        s_axi_wvalid <= 1'h0;
        w_done = 1'h1;
      end
    end
    do begin
      @(negedge aclk);
      got = s_axi_bvalid;
      @(posedge aclk);
    end while (!got);
    s_axi_bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [7:0] e,
                          input logic [1:0] r);
    logic got;
    @(posedge aclk);
    rq.push_back('{data: {24'h0, e}, resp: r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      got = s_axi_arready;
      @(posedge aclk);
    end while (!got);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      got = s_axi_rvalid;
      @(posedge aclk);
    end while (!got);
    s_axi_rready <= 1'h0;
  endtask : axi_read

  task automatic pulse_src(input logic ea, input logic er);
    repeat (2) @(posedge aclk);
    src_change <= 1'h1;
    @(posedge aclk);
    src_change <= 1'h0;
    @(negedge aclk);
    cmp_port("phase_absorb", {7'h0, ea}, {7'h0, phase_absorb});
    cmp_port("phase_realign", {7'h0, er}, {7'h0, phase_realign});
  endtask : pulse_src

  // ---------------------------------------------------------------
  // Response monitor: oldest note against each handshake
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      if (bq.size() == 0) begin
        cmp_bus("bresp_unexpected", 32'h1, 32'h0);
      end else begin
        nt = bq.pop_front();
        cmp_bus("bresp", {30'h0, nt.resp}, {30'h0, s_axi_bresp});
      end
    end
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      if (rq.size() == 0) begin
        cmp_bus("rdata_unexpected", 32'h1, 32'h0);
      end else begin
        nt = rq.pop_front();
        cmp_bus("rdata", nt.data, s_axi_rdata);
        cmp_bus("rresp", {30'h0, nt.resp}, {30'h0, s_axi_rresp});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] ppm [4];
    ppm = '{dsc_pkg::PPM_12, dsc_pkg::PPM_52, dsc_pkg::PPM_130,
            dsc_pkg::PPM_83};
    void'($urandom(32'h459B9870));
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_rready, tx_state, src_change} = '0;
    fails = 0;
    checks = 0;
    aresetn = 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    cmp_port("span_ppm", dsc_pkg::PPM_83, span_ppm);
    cmp_port("slope_cap_ms", dsc_pkg::SLOPE_CAP_MS, slope_cap_ms);
    cmp_port("rx_ctrl", 8'h00, {3'h0, rx_ctrl});
    axi_read(dsc_pkg::ADDR_SPAN, 8'h03, dsc_pkg::RESP_OKAY);
    axi_read(dsc_pkg::ADDR_RX_CTRL_A, 8'h00, dsc_pkg::RESP_OKAY);
    axi_read(dsc_pkg::ADDR_RX_CTRL_B, 8'h04, dsc_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      tx_state <= dsc_pkg::dsc_tx_state_t'(3'(i));
      repeat (3) @(posedge aclk);
      axi_read(dsc_pkg::ADDR_TX_STATE, {5'h0, 3'(i)}, 2'h0);
    end
    // Status is read-only: the write is answered but changes nothing.
    axi_write(dsc_pkg::ADDR_TX_STATE, 8'h00, 4'h1, dsc_pkg::RESP_OKAY);
    axi_read(dsc_pkg::ADDR_TX_STATE, 8'h07, dsc_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      axi_write(dsc_pkg::ADDR_SPAN, {6'h00, 2'(i)}, 4'h1, 2'h0);
      axi_read(dsc_pkg::ADDR_SPAN, {6'h0, 2'(i)}, 2'h0);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      cmp_port("span_code", {6'h0, 2'(i)}, {6'h0, span_code});
      cmp_port("span_ppm", ppm[i], span_ppm);
    end
    axi_write(dsc_pkg::ADDR_SPAN, 8'h00, 4'h0, dsc_pkg::RESP_OKAY);
    axi_read(dsc_pkg::ADDR_SPAN, 8'h03, dsc_pkg::RESP_OKAY);
    for (int j = 0; j < 8; j++) begin
      // Software keeps reserved bits at their defaults.
      a = 8'($urandom) & 8'h91;
      a[4] = j[2];
      b = {6'h01, 2'(j)};
      axi_write(dsc_pkg::ADDR_RX_CTRL_A, a, 4'h1, 2'h0);
      axi_write(dsc_pkg::ADDR_RX_CTRL_B, b, 4'h1, 2'h0);
      axi_read(dsc_pkg::ADDR_RX_CTRL_A, a & 8'h91, 2'h0);
      axi_read(dsc_pkg::ADDR_RX_CTRL_B, {6'h1, b[1:0]}, 2'h0);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      cmp_port("rx_ctrl", {3'h0, a[7], b[1], b[0], a[4], a[0]},
               {3'h0, rx_ctrl});
      cmp_port("slope_cap_ms", a[4] ? 8'h00 : 8'h3D, slope_cap_ms);
    end
    // Unmapped place: refused on both channels.
    axi_write(8'hB0, 8'h5A, 4'h1, dsc_pkg::RESP_SLVERR);
    axi_read(8'hB0, 8'h00, dsc_pkg::RESP_SLVERR);
    axi_write(dsc_pkg::ADDR_RX_CTRL_A, 8'h80, 4'h1, 2'h0);
    pulse_src(1'h1, 1'h0);
    axi_write(dsc_pkg::ADDR_RX_CTRL_A, 8'h81, 4'h1, 2'h0);
    pulse_src(1'h0, 1'h1);
    axi_write(dsc_pkg::ADDR_RX_CTRL_A, 8'h01, 4'h1, 2'h0);
    pulse_src(1'h0, 1'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(dsc_pkg::ADDR_SPAN, 8'h03, dsc_pkg::RESP_OKAY);
    axi_read(dsc_pkg::ADDR_RX_CTRL_A, 8'h00, dsc_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    tally_and_finish();
  end

endmodule : tb_top
